/* touch_spi_pkg.sv */
/*
 * touch_spi_pkg: shared constants and carriers for the touch controller
 * serial port and its register store.
 * Assumes: a 16-word by 16-bit register space and SPI mode 0 framing.
 */
package touch_spi_pkg;

	// ==========================================================
	// frame layout
	localparam int unsigned HDR_BITS = 8;
	localparam int unsigned FRAME_BITS = 24;
	localparam int unsigned CNT_W = 5;
	localparam logic [CNT_W-1:0] HDR_LAST = 5'h07;
	localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
	localparam int unsigned REG_W = 16;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned REG_DEPTH = 16;

	// ==========================================================
	// register space
	localparam logic [ADDR_W-1:0] RESULT_TOP = 4'h7;
	localparam logic [ADDR_W-1:0] CFG_ADDR = 4'h8;
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam logic [REG_W-1:0] CFG_RESET = 16'h0002;
	localparam int unsigned IRQ_MODE_LSB = 0;

	// ==========================================================
	// interrupt pin source selection
	localparam logic [1:0] IRQ_PEN = 2'h0;
	localparam logic [1:0] IRQ_DAV = 2'h1;
	localparam logic [1:0] IRQ_BOTH = 2'h2;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic is_cmd;
		logic [ADDR_W-1:0] addr;
		logic rd;
		logic [1:0] rsvd;
	} hdr_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0] data;
	} reg_acc_s;

	// result words live in the low half of the register space
	function automatic logic is_result_addr(input logic [ADDR_W-1:0] a);
		return a <= RESULT_TOP;
	endfunction

endpackage

/* touch_reg_store.sv */
/*
 * touch_reg_store: small register array with one write port and one
 * registered read port; every word returns to its default on reset.
 * Assumes: one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module touch_reg_store
	import touch_spi_pkg::*;
#(
	parameter int unsigned DEPTH = REG_DEPTH,
	parameter int unsigned WIDTH = REG_W,
	parameter int unsigned AW = $clog2(DEPTH),
	parameter logic [AW-1:0] SPECIAL_IDX = CFG_ADDR,
	parameter logic [WIDTH-1:0] SPECIAL_VAL = CFG_RESET
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("touch_reg_store: DEPTH must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem_q [DEPTH];

	// ==========================================================
	// write port with reset to defaults
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= (i == int'(SPECIAL_IDX)) ? SPECIAL_VAL : WIDTH'(REG_RESET);
			end
		end else if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// registered read port, independent of writes
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem_q[rd_addr];
		end
	end

endmodule // touch_reg_store

`default_nettype wire

/* touch_serial_port.sv */
/*
 * touch_serial_port: SPI mode 0 slave port of a touch screen controller,
 * with register store, command strobe and programmable interrupt pin.
 * Assumes: serial pins arrive asynchronously and are oversampled by clk;
 * each serial clock phase lasts at least three clk periods.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - serial port runs SPI mode 0; clock idles low, output never moves on rise.
// - serial data output changes only on falling serial clock edges.
// - serial data input is sampled on rising serial clock edges.
// - single-byte command takes exactly eight serial clocks, all required.
// - register access takes 24 serial clocks, all required to complete.
// - several cycles may run under one chip select, each with its address.
// - device is slave only; host makes the serial clock.
// - host writes to addressed registers control the device.
// - results sit in registers, readable any time without disturbance.
// - interrupt pin flags pen touch, data available, or both.
// - interrupt pin asserts low.
// - system reset returns every register to its default.
module touch_serial_port
	import touch_spi_pkg::*;
#(
	parameter int unsigned DATA_W = REG_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic pen_touch_flag,
	input wire logic result_valid,
	input wire reg_acc_s result,
	output logic result_ready,
	output logic cmd_valid,
	output logic [HDR_BITS-2:0] cmd_code,
	output logic touch_data_irq_out_n
);

	generate
		if (DATA_W != REG_W) begin : g_bad_width
			$error("touch_serial_port: DATA_W must equal the register width");
		end
	endgenerate

	typedef enum logic {PH_HEAD, PH_DATA} phase_e;

	// ==========================================================
	// input synchronisers
	logic sclk_m_q, sclk_s_q, sclk_d_q;
	logic cs_m_q, cs_s_q;
	logic mosi_m_q, mosi_s_q;
	logic pen_m_q, pen_s_q;

	// two flops per pin, then a third for sclk edge finding
	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_m_q <= 1'b0;
			sclk_s_q <= 1'b0;
			sclk_d_q <= 1'b0;
			cs_m_q <= 1'b1;
			cs_s_q <= 1'b1;
			mosi_m_q <= 1'b0;
			mosi_s_q <= 1'b0;
			pen_m_q <= 1'b0;
			pen_s_q <= 1'b0;
		end else begin
			sclk_m_q <= sclk;
			sclk_s_q <= sclk_m_q;
			sclk_d_q <= sclk_s_q;
			cs_m_q <= cs_n;
			cs_s_q <= cs_m_q;
			mosi_m_q <= mosi;
			mosi_s_q <= mosi_m_q;
			pen_m_q <= pen_touch_flag;
			pen_s_q <= pen_m_q;
		end
	end

	logic sel, rise, fall;
	// host-made clock edges, seen only while selected
	assign sel = ~cs_s_q;
	assign rise = sel & sclk_s_q & ~sclk_d_q;
	assign fall = sel & ~sclk_s_q & sclk_d_q;

	// ==========================================================
	// frame tracking
	phase_e phase_q;
	logic [CNT_W-1:0] cnt_q;
	logic [FRAME_BITS-1:0] in_q;
	hdr_s hdr_q, hdr_now;
	logic [DATA_W-1:0] wdata_now;

	assign hdr_now = hdr_s'({in_q[HDR_BITS-2:0], mosi_s_q});
	assign wdata_now = {in_q[DATA_W-2:0], mosi_s_q};

	// shift in on rise, count clocks, restart after each complete cycle
	always_ff @(posedge clk) begin
		if (srst || !sel) begin
			cnt_q <= '0;
			phase_q <= PH_HEAD;
			in_q <= '0;
			hdr_q <= '0;
		end else if (rise) begin
			in_q <= {in_q[FRAME_BITS-2:0], mosi_s_q};
			case (phase_q)
				PH_HEAD: begin
					if (cnt_q == HDR_LAST) begin
						hdr_q <= hdr_now;
						cnt_q <= hdr_now.is_cmd ? '0 : cnt_q + 5'h01;
						phase_q <= hdr_now.is_cmd ? PH_HEAD : PH_DATA;
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				PH_DATA: begin
					if (cnt_q == FRAME_LAST) begin
						cnt_q <= '0;
						phase_q <= PH_HEAD;
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				default: begin
					cnt_q <= '0;
					phase_q <= PH_HEAD;
				end
			endcase
		end
	end

	logic hdr_done, frame_done;
	assign hdr_done = rise && phase_q == PH_HEAD && cnt_q == HDR_LAST;
	assign frame_done = rise && phase_q == PH_DATA && cnt_q == FRAME_LAST;

	// ==========================================================
	// command strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_valid <= 1'b0;
			cmd_code <= '0;
		end else begin
			cmd_valid <= hdr_done && hdr_now.is_cmd;
			if (hdr_done && hdr_now.is_cmd) begin
				cmd_code <= {hdr_now.addr, hdr_now.rd, hdr_now.rsvd};
			end
		end
	end

	// ==========================================================
	// host register writes
	logic spi_wr_q;
	reg_acc_s spi_acc_q;
	logic [1:0] irq_mode_q;

	// full 24-clock write to a control word only
	always_ff @(posedge clk) begin
		if (srst) begin
			spi_wr_q <= 1'b0;
			spi_acc_q <= '0;
		end else begin
			spi_wr_q <= frame_done && !hdr_q.rd && !is_result_addr(hdr_q.addr);
			if (frame_done) begin
				spi_acc_q <= '{addr: hdr_q.addr, data: wdata_now};
			end
		end
	end

	// interrupt source selection shadows the configuration word
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_mode_q <= CFG_RESET[IRQ_MODE_LSB +: 2];
		end else if (spi_wr_q && spi_acc_q.addr == CFG_ADDR) begin
			irq_mode_q <= spi_acc_q.data[IRQ_MODE_LSB +: 2];
		end
	end

	// ==========================================================
	// measurement results
	logic res_pend_q, res_commit;
	reg_acc_s res_hold_q;
	assign res_commit = res_pend_q && !spi_wr_q;

	// one-word hold; host writes take the port first
	always_ff @(posedge clk) begin
		if (srst) begin
			res_pend_q <= 1'b0;
			res_hold_q <= '0;
			result_ready <= 1'b0;
		end else begin
			if (result_valid && result_ready) begin
				res_pend_q <= 1'b1;
				res_hold_q <= result;
				result_ready <= 1'b0;
			end else if (res_commit) begin
				res_pend_q <= 1'b0;
				result_ready <= 1'b1;
			end else begin
				result_ready <= !res_pend_q;
			end
		end
	end

	logic wr_en;
	logic [ADDR_W-1:0] wr_addr, rd_addr_q;
	logic [DATA_W-1:0] wr_data, rd_data;
	assign wr_en = spi_wr_q | res_commit;
	assign wr_addr = spi_wr_q ? spi_acc_q.addr : res_hold_q.addr;
	assign wr_data = spi_wr_q ? spi_acc_q.data : res_hold_q.data;

	touch_reg_store #(
		.DEPTH(REG_DEPTH),
		.WIDTH(DATA_W),
		.AW(ADDR_W),
		.SPECIAL_IDX(CFG_ADDR),
		.SPECIAL_VAL(CFG_RESET)
	) u_store (
		.clk(clk),
		.srst(srst),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr_q),
		.rd_data(rd_data)
	);

	// ==========================================================
	// data available flag
	logic dav_q;
	logic rd_res_done;
	assign rd_res_done = frame_done && hdr_q.rd && is_result_addr(hdr_q.addr);

	// new result sets, completed result read clears, set wins
	always_ff @(posedge clk) begin
		if (srst) begin
			dav_q <= 1'b0;
		end else if (res_commit) begin
			dav_q <= 1'b1;
		end else if (rd_res_done) begin
			dav_q <= 1'b0;
		end
	end

	// ==========================================================
	// read path and serial output
	logic [1:0] load_q;
	logic [DATA_W-1:0] out_q;

	// address latch, then two cycles to registered read data
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_addr_q <= '0;
			load_q <= 2'h0;
		end else begin
			if (hdr_done && hdr_now.rd && !hdr_now.is_cmd) begin
				rd_addr_q <= hdr_now.addr;
			end
			load_q <= {load_q[0], hdr_done && hdr_now.rd && !hdr_now.is_cmd};
		end
	end

	// output word loads from the read port, then shifts only on falling sclk
	always_ff @(posedge clk) begin
		if (srst || !sel) begin
			out_q <= '0;
			miso <= 1'b0;
		end else if (load_q[1]) begin
			out_q <= rd_data;
		end else if (fall) begin
			if (phase_q == PH_DATA) begin
				miso <= out_q[DATA_W-1];
				out_q <= {out_q[DATA_W-2:0], 1'b0};
			end else begin
				miso <= 1'b0;
			end
		end
	end

	// release the line whenever deselected
	always_ff @(posedge clk) begin
		if (srst) begin
			miso_oe <= 1'b0;
		end else begin
			miso_oe <= sel;
		end
	end

	// ==========================================================
	// interrupt pin
	logic irq_act;
	always_comb begin
		case (irq_mode_q)
			IRQ_PEN: irq_act = pen_s_q;
			IRQ_DAV: irq_act = dav_q;
			default: irq_act = pen_s_q | dav_q;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			touch_data_irq_out_n <= 1'b1;
		end else begin
			touch_data_irq_out_n <= ~irq_act;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_hdr_cmd;
		hdr_done && hdr_now.is_cmd;
	endsequence

	sequence s_write_end;
		frame_done && !hdr_q.rd && !is_result_addr(hdr_q.addr);
	endsequence

	property p_mode0_rise;
		rise |=> $stable(miso);
	endproperty
	a_mode0_rise: assert property (p_mode0_rise) else $error("miso moved on a rising edge");

	property p_miso_on_fall;
		sel && $past(sel) && $changed(miso) |-> $past(fall);
	endproperty
	a_miso_on_fall: assert property (p_miso_on_fall) else $error("miso moved without a falling edge");

	property p_count_on_rise;
		sel && rise && cnt_q != HDR_LAST && cnt_q != FRAME_LAST |=> cnt_q == $past(cnt_q) + 5'h01;
	endproperty
	a_count_on_rise: assert property (p_count_on_rise) else $error("rising edge not counted");

	property p_cmd_len;
		s_hdr_cmd |=> cmd_valid && cnt_q == '0 ##1 !cmd_valid;
	endproperty
	a_cmd_len: assert property (p_cmd_len) else $error("command byte not closed after eight clocks");

	property p_write_len;
		s_write_end |=> spi_wr_q ##1 !spi_wr_q;
	endproperty
	a_write_len: assert property (p_write_len) else $error("write not issued after 24 clocks");

	property p_back_to_back;
		frame_done |=> cnt_q == '0 && phase_q == PH_HEAD;
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("next cycle does not restart");

	property p_cfg_write;
		spi_wr_q && spi_acc_q.addr == CFG_ADDR |=> irq_mode_q == $past(spi_acc_q.data[IRQ_MODE_LSB +: 2]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("configuration write lost");

	property p_result_flag;
		res_commit |=> dav_q;
	endproperty
	a_result_flag: assert property (p_result_flag) else $error("data available not raised");

	property p_irq_dav;
		irq_mode_q == IRQ_DAV && dav_q |=> !touch_data_irq_out_n;
	endproperty
	a_irq_dav: assert property (p_irq_dav) else $error("data available not flagged");

	property p_irq_low;
		irq_mode_q == IRQ_PEN && !pen_s_q |=> touch_data_irq_out_n;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("interrupt pin low without a cause");

	property p_reset;
		disable iff (1'b0) srst |=> cnt_q == '0 && irq_mode_q == CFG_RESET[IRQ_MODE_LSB +: 2] && !dav_q && !miso_oe;
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not restore defaults");

	property p_release;
		!sel |=> !miso_oe;
	endproperty
	a_release: assert property (p_release) else $error("miso driven while deselected");

endmodule // touch_serial_port

`default_nettype wire

/* host_spi_model.sv */
/*
 * host_spi_model: behavioural SPI mode 0 master standing in for the host.
 * Assumes: the bench resolves the shared serial output wire into miso.
 */
`timescale 1ns/1ps
`default_nettype none

module host_spi_model #(
	parameter int HALF_NS = 80
) (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	// ==========================================================
	// idle levels: clock low, no frame open
	initial begin
		sclk = 1'h0;
		cs_n = 1'h1;
		mosi = 1'h1;
	end

	// open a frame, lead time before first rise
	task automatic select();
		cs_n = 1'h0;
		#(HALF_NS);
	endtask

	// close a frame; released data line stops showing the last bit
	task automatic deselect();
		#(HALF_NS);
		cs_n = 1'h1;
		mosi = ~mosi;
		#(HALF_NS);
	endtask

	// shift n bits msb first, master makes every clock and samples on rise
	task automatic shift(input int n, input logic [23:0] tx, output logic [23:0] rx);
		rx = '0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = tx[i];
			#(HALF_NS);
			sclk = 1'h1;
			rx[i] = miso;
			#(HALF_NS);
			sclk = 1'h0;
		end
	endtask
endmodule // host_spi_model

`default_nettype wire

/* test_touch_controller_serial_port.sv */
/*
 * test_touch_controller_serial_port: self-checking bench for the serial port.
 * Assumes: host_spi_model drives the link; 8 ns clk, 160 ns serial clock.
 */
`timescale 1ns/1ps
`default_nettype none

module test_touch_controller_serial_port;
	import touch_spi_pkg::*;

	logic clk = 1'h0;
	logic srst = 1'h1;
	logic sclk, cs_n, mosi, miso, miso_oe;
	logic pen_touch_flag = 1'h0;
	logic result_valid = 1'h0;
	reg_acc_s result = '0;
	logic result_ready, cmd_valid, touch_data_irq_out_n;
	logic [HDR_BITS-2:0] cmd_code, last_code;
	wire miso_w = miso_oe ? miso : 1'bz;
	int miscompares = 0;
	int n_checks = 0;
	int n_cmd = 0;
	logic [23:0] rx;
	logic [15:0] d;

	// ==========================================================
	// clock, device and host
	always #4 clk = ~clk;

	touch_serial_port DUT (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .pen_touch_flag(pen_touch_flag), .result_valid(result_valid), .result(result),
		.result_ready(result_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.touch_data_irq_out_n(touch_data_irq_out_n));

	host_spi_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));

	// ==========================================================
	// compares and closing
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		chk16({15'h0, got}, {15'h0, exp}, what);
	endtask

	task automatic end_sim();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// command pulses counted mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (cmd_valid === 1'h1) begin
			n_cmd++;
			last_code = cmd_code;
		end
	end

	// output line must not move while the serial clock is high
	always @(miso) begin
		if (miso_oe === 1'h1) begin
			chk1(sclk, 1'h0, "miso moved on high clock");
		end
	end

	// ==========================================================
	// frame helpers
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		host.select();
		host.shift(24, {1'h0, a, 1'h0, 2'h0, v}, rx);
		host.deselect();
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		host.select();
		host.shift(24, {1'h0, a, 1'h1, 2'h0, 16'h0}, rx);
		host.deselect();
		v = rx[15:0];
	endtask

	task automatic settle();
		repeat (8) @(negedge clk);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk1(touch_data_irq_out_n, 1'h1, "irq idle");
		chk1(miso_oe, 1'h0, "oe idle");
		chk1(result_ready, 1'h1, "ready after reset");
		rd(CFG_ADDR, d);
		chk16(d, CFG_RESET, "config default");
		rd(4'h3, d);
		chk16(d, REG_RESET, "result default");
		settle();
		chk1(miso_oe, 1'h0, "oe released");
	endtask

	task automatic t_irq();
		wr(CFG_ADDR, {14'h0, IRQ_PEN});
		@(negedge clk) pen_touch_flag = 1'h1;
		settle();
		chk1(touch_data_irq_out_n, 1'h0, "pen mode");
		wr(CFG_ADDR, {14'h0, IRQ_DAV});
		rd(CFG_ADDR, d);
		chk16(d, {14'h0, IRQ_DAV}, "config readback");
		chk1(touch_data_irq_out_n, 1'h1, "pen masked");
		@(negedge clk) pen_touch_flag = 1'h0;
		result_valid = 1'h1;
		result = '{addr: 4'h3, data: 16'hA5C3};
		for (int i = 0; i < 20 && result_ready !== 1'h1; i++) @(negedge clk);
		@(negedge clk) result_valid = 1'h0;
		chk1(result_ready, 1'h0, "hold slot taken");
		settle();
		chk1(result_ready, 1'h1, "hold slot free");
		chk1(touch_data_irq_out_n, 1'h0, "data available");
		rd(4'h3, d);
		chk16(d, 16'hA5C3, "result word");
		settle();
		chk1(touch_data_irq_out_n, 1'h1, "cleared by read");
		wr(CFG_ADDR, {14'h0, IRQ_BOTH});
		@(negedge clk) pen_touch_flag = 1'h1;
		settle();
		chk1(touch_data_irq_out_n, 1'h0, "both mode pen");
		@(negedge clk) pen_touch_flag = 1'h0;
		settle();
		chk1(touch_data_irq_out_n, 1'h1, "both mode idle");
	endtask

	task automatic t_readonly();
		wr(4'h2, 16'hFFFF);
		rd(4'h2, d);
		chk16(d, REG_RESET, "result place not writable");
	endtask

	task automatic t_abort();
		host.select();
		host.shift(5, 24'h00001F, rx);
		host.deselect();
		host.select();
		host.shift(12, {1'h0, 4'h9, 1'h0, 2'h0, 4'hF}, rx);
		host.deselect();
		settle();
		chk16(16'(n_cmd), 16'h0000, "partial command");
		rd(4'h9, d);
		chk16(d, REG_RESET, "partial write");
	endtask

	task automatic t_burst();
		host.select();
		host.shift(8, {16'h0, 1'h1, 7'h5A}, rx);
		host.shift(24, {1'h0, 4'h9, 1'h0, 2'h0, 16'h3C5A}, rx);
		host.shift(8, {16'h0, 1'h1, 7'h01}, rx);
		host.shift(24, {1'h0, 4'h9, 1'h1, 2'h0, 16'h0}, rx);
		host.deselect();
		settle();
		chk16(rx[15:0], 16'h3C5A, "burst readback");
		chk16(16'(n_cmd), 16'h0002, "command count");
		chk16({9'h0, last_code}, 16'h0001, "command code");
		chk1(miso_oe, 1'h0, "oe after burst");
	endtask

	// reset in mid-run: written words and interrupt source go back to defaults
	task automatic t_midreset();
		wr(CFG_ADDR, {14'h0, IRQ_DAV});
		@(negedge clk) pen_touch_flag = 1'h1;
		settle();
		chk1(touch_data_irq_out_n, 1'h1, "pen masked before reset");
		srst = 1'h1;
		repeat (3) @(negedge clk);
		chk1(touch_data_irq_out_n, 1'h1, "irq held in reset");
		chk1(miso_oe, 1'h0, "oe held in reset");
		srst = 1'h0;
		settle();
		chk1(touch_data_irq_out_n, 1'h0, "default mode passes pen");
		@(negedge clk) pen_touch_flag = 1'h0;
		rd(CFG_ADDR, d);
		chk16(d, CFG_RESET, "config restored");
		rd(4'h9, d);
		chk16(d, REG_RESET, "control word restored");
		rd(4'h3, d);
		chk16(d, REG_RESET, "result word restored");
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (3) @(negedge clk);
		srst = 1'h0;
		repeat (3) @(negedge clk);
		t_reset();
		t_irq();
		t_readonly();
		t_abort();
		t_burst();
		t_midreset();
		end_sim();
	end

	initial begin
		#300000;
		miscompares++;
		end_sim();
	end
endmodule // test_touch_controller_serial_port

`default_nettype wire
